// ===== phir_func_decode.sv
`timescale 1ns/10ps
module phir_func_decode (
	input  wire logic [4:0] device,        // Addressed device number.
	input  wire logic [2:0] function_,     // Addressed function number.
	output logic            covered,       // Function is one this block answers for.
	output logic            isPort,        // Function is an express port bridge.
	output logic            hasSubsystem,  // Function carries the subsystem registers.
	output logic            multiFunction, // Multi-function flag value.
	output logic [7:0]      subClass       // Sub-class value.
);
	always_comb begin
		isPort        = (device >= phir_pkg::DEV_PORT_FIRST) &&
		                (device <= phir_pkg::DEV_PORT_LAST) && (function_ == 3'h0);
		multiFunction = (device == phir_pkg::DEV_MULTI_A) ||
		                (device == phir_pkg::DEV_MULTI_B) ||
		                (device == phir_pkg::DEV_MULTI_C);
		covered       = 1'b0;
		hasSubsystem  = 1'b0;
		if ((device == phir_pkg::DEV_HOST || device == phir_pkg::DEV_SINGLE) &&
		    function_ == 3'h0) begin
			covered      = 1'b1;
			hasSubsystem = 1'b1;
		end else if (isPort) begin
			covered      = 1'b1;
		end else if (device == phir_pkg::DEV_MULTI_A &&
		             function_ <= phir_pkg::FN_MULTI_A_LAST) begin
			covered      = 1'b1;
			hasSubsystem = function_ <= phir_pkg::FN_SUBSYS_A_LAST;
		end else if ((device == phir_pkg::DEV_MULTI_B || device == phir_pkg::DEV_MULTI_C) &&
		             function_ <= phir_pkg::FN_MULTI_BC_LAST) begin
			covered      = 1'b1;
			hasSubsystem = 1'b1;
		end
		subClass = isPort ? phir_pkg::SUB_CLASS_P2P : phir_pkg::SUB_CLASS_HOST;
	end
endmodule : phir_func_decode

// ===== phir_header_ident_regs.sv
// Operation
// - Writes to the class code register at 09h are ignored and reads keep the fixed value.
// - The base class field in bits 23:16 always reads 06h, a bridge device.
// - The sub-class in bits 15:8 reads 04h for port devices 1 to 9 and 00h for the rest.
// - The programming-interface field in bits 7:0 always reads 00h.
// - Header-type bit 7 reads one for devices 16, 21 and 22 and zero for all others.
// - Header-type bits 6:0 read 01h for port devices 1 to 9 and 00h for the rest.
// - The header-type byte at 0Eh is read-only and writes leave it unchanged.
// - Each byte of the subsystem vendor register at 2Ch takes only its first write.
// - A subsystem vendor write through any function but the ports and device 16 functions 3 and 4 updates the copy seen by all of them.
// - Each byte of the subsystem identity register at 2Eh takes only its first write.
// - The subsystem identity register exists in every covered function but the ports and device 16 functions 3 and 4.
`timescale 1ns/10ps
module phir_header_ident_regs (
	input  wire logic        clock,         // Core clock, 125 MHz.
	input  wire logic        reset,         // Synchronous system reset, active high.
	input  wire logic        cfgRead,       // Configuration read request.
	input  wire logic        cfgWrite,      // Configuration write request.
	input  wire logic [4:0]  cfgDevice,     // Target device number.
	input  wire logic [2:0]  cfgFunction,   // Target function number.
	input  wire logic [5:0]  cfgDword,      // Dword index, byte offset bits 7:2.
	input  wire logic [3:0]  cfgByteEnable, // Byte enables, bit n for lane n.
	input  wire logic [31:0] cfgWriteData,  // Write data.
	output logic [31:0]      cfgReadData,   // Read data, registered.
	output logic             cfgReadValid,  // Read data valid, one-cycle pulse.
	output logic             cfgClaim,      // Addressed function is covered here.
	output logic [1:0]       makerLocked,   // Subsystem vendor bytes already written.
	output logic [1:0]       identLocked    // Subsystem identity bytes already written.
);
	logic        covered;
	logic        isPort;
	logic        hasSubsystem;
	logic        multiFunction;
	logic [7:0]  subClass;
	logic [23:0] classCode;
	logic [7:0]  headerLayout;
	logic [31:0] subsysWord;
	logic [3:0]  subsysLocked;
	logic [3:0]  subsysWrite;
	logic [31:0] readWord;
	logic [31:0] next_cfgReadData;
	logic        next_cfgReadValid;

	phir_func_decode u_decode (
		.device        (cfgDevice),
		.function_     (cfgFunction),
		.covered       (covered),
		.isPort        (isPort),
		.hasSubsystem  (hasSubsystem),
		.multiFunction (multiFunction),
		.subClass      (subClass)
	);

	assign cfgClaim = covered;

	// The class code and header bytes are pure functions of the address,
	// so no storage exists that a write could reach.
	always_comb begin
		classCode = '0;
		classCode[phir_pkg::BASE_CLASS_LSB +: 8] = phir_pkg::BASE_CLASS_BRIDGE;
		classCode[phir_pkg::SUB_CLASS_LSB +: 8]  = subClass;
		classCode[phir_pkg::PROG_IF_LSB +: 8]    = phir_pkg::PROG_IF_NONE;
		headerLayout = {multiFunction,
		                isPort ? phir_pkg::LAYOUT_BRIDGE : phir_pkg::LAYOUT_NORMAL};
	end

	// One shared copy serves every function, so a write through any one
	// is seen by all at once; ports and device 16 functions 3 and 4 neither see nor write it.
	always_comb begin
		subsysWrite = '0;
		if (cfgWrite && covered && hasSubsystem && cfgDword == phir_pkg::SUBSYS_DW) begin
			subsysWrite = cfgByteEnable;
		end
	end

	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_subsys
			localparam logic [31:0] RESET_WORD =
				{phir_pkg::SUBSYS_IDENT_RESET, phir_pkg::SUBSYS_MAKER_RESET};
			phir_once_byte #(
				.RESET_VALUE (RESET_WORD[lane*8 +: 8])
			) u_byte (
				.clock     (clock),
				.reset     (reset),
				.write     (subsysWrite[lane]),
				.writeData (cfgWriteData[lane*8 +: 8]),
				.value     (subsysWord[lane*8 +: 8]),
				.locked    (subsysLocked[lane])
			);
		end
	endgenerate

	assign makerLocked = subsysLocked[phir_pkg::SUBSYS_MAKER_LANE +: 2];
	assign identLocked = subsysLocked[phir_pkg::SUBSYS_IDENT_LANE +: 2];

	// Read path; writes to the class and header dwords fall through here
	// untouched, which is what keeps them read-only.
	always_comb begin
		readWord = '0;
		if (covered) begin
			unique case (cfgDword)
				phir_pkg::CLASS_CODE_DW: begin
					readWord[phir_pkg::CLASS_CODE_LANE*8 +: 24] = classCode;
				end
				phir_pkg::HEADER_LAYOUT_DW: begin
					readWord[phir_pkg::HEADER_LAYOUT_LANE*8 +: 8] = headerLayout;
				end
				phir_pkg::SUBSYS_DW: begin
					if (hasSubsystem) begin
						readWord = subsysWord;
					end
				end
				default: begin
					readWord = '0;
				end
			endcase
		end
		next_cfgReadValid = cfgRead;
		next_cfgReadData  = cfgRead ? readWord : cfgReadData;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			cfgReadData  <= 32'h0000_0000;
			cfgReadValid <= 1'b0;
		end else begin
			cfgReadData  <= next_cfgReadData;
			cfgReadValid <= next_cfgReadValid;
		end
	end
endmodule : phir_header_ident_regs

// ===== phir_header_ident_regs_checker.sv
`timescale 1ns/10ps
module phir_header_ident_regs_checker (
	input wire logic        clock,         // Core clock.
	input wire logic        reset,         // Synchronous reset.
	input wire logic        cfgRead,       // Read request.
	input wire logic        cfgWrite,      // Write request.
	input wire logic [4:0]  cfgDevice,     // Device number.
	input wire logic [2:0]  cfgFunction,   // Function number.
	input wire logic [5:0]  cfgDword,      // Dword index.
	input wire logic [3:0]  cfgByteEnable, // Byte enables.
	input wire logic [31:0] cfgWriteData,  // Write data.
	input wire logic [31:0] cfgReadData,   // Read data.
	input wire logic        cfgReadValid,  // Read valid.
	input wire logic        cfgClaim,      // Function covered.
	input wire logic [1:0]  makerLocked,   // Vendor byte locks.
	input wire logic [1:0]  identLocked    // Identity byte locks.
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	logic isPortDev;
	logic isMulti;
	assign isPortDev = cfgDevice >= 5'h01 && cfgDevice <= 5'h09;
	assign isMulti = cfgDevice == 5'h10 || cfgDevice == 5'h15 || cfgDevice == 5'h16;
	sequence classRead;
		cfgRead && cfgClaim && cfgDword == 6'h02;
	endsequence
	sequence headRead;
		cfgRead && cfgClaim && cfgDword == 6'h03;
	endsequence
	a_class_port: assert property (classRead ##0 isPortDev |=>
		cfgReadValid && cfgReadData == 32'h06040000) else $error("port class code wrong");
	a_class_host: assert property (classRead ##0 !isPortDev |=>
		cfgReadData == 32'h06000000) else $error("host class code wrong");
	// The programming interface sits in lane 1; lane 0 is the revision byte.
	a_prog_if_zero: assert property (classRead |=> cfgReadData[15:8] == 8'h00)
		else $error("programming interface not zero");
	a_layout_port: assert property (headRead ##0 isPortDev |=>
		cfgReadData == 32'h00010000) else $error("port header byte wrong");
	a_multi_flag: assert property (headRead ##0 isMulti |=>
		cfgReadData[23:16] == 8'h80) else $error("multi-function flag wrong");
	a_lock_holds: assert property (!$past(reset) |->
		($past(makerLocked) & ~makerLocked) == 2'b00) else $error("lock cleared without reset");
	a_ident_cause: assert property (!$past(reset) &&
		(identLocked & ~$past(identLocked)) != 2'b00 |-> $past(cfgWrite))
		else $error("identity locked without write");
	a_maker_once: assert property (cfgWrite && cfgDevice == 5'h00 && cfgFunction == 3'h0
		&& cfgDword == 6'h0b && cfgByteEnable[0] |=> makerLocked[0])
		else $error("vendor byte not locked");
	a_maker_shared: assert property (cfgWrite && cfgDevice == 5'h10
		&& cfgFunction == 3'h1 && cfgDword == 6'h0b && cfgByteEnable[0] |=> makerLocked[0])
		else $error("shared vendor byte not locked");
	a_port_no_write: assert property (cfgWrite && isPortDev |=>
		$stable(identLocked) && $stable(makerLocked)) else $error("port write changed locks");
endmodule : phir_header_ident_regs_checker

bind phir_header_ident_regs phir_header_ident_regs_checker u_checker (
	.clock(clock), .reset(reset), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
	.cfgDevice(cfgDevice), .cfgFunction(cfgFunction), .cfgDword(cfgDword),
	.cfgByteEnable(cfgByteEnable), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
	.cfgReadValid(cfgReadValid), .cfgClaim(cfgClaim), .makerLocked(makerLocked),
	.identLocked(identLocked));

// ===== phir_header_ident_regs_tb.sv
`timescale 1ns/10ps
module phir_header_ident_regs_tb;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        cfgRead = 1'b0;
	logic        cfgWrite = 1'b0;
	logic [4:0]  cfgDevice = 5'h00;
	logic [2:0]  cfgFunction = 3'h0;
	logic [5:0]  cfgDword = 6'h00;
	logic [3:0]  cfgByteEnable = 4'h0;
	logic [31:0] cfgWriteData = 32'h0;
	logic [31:0] cfgReadData;
	logic        cfgReadValid;
	logic        cfgClaim;
	logic [1:0]  makerLocked;
	logic [1:0]  identLocked;
	int          error_cnt = 0;
	int          samples_checked = 0;
	// Each row is device, function, dword index and the expected read word.
	logic [45:0] rows [15] = '{
		{5'h00, 3'h0, 6'h02, 32'h06000000}, {5'h00, 3'h0, 6'h03, 32'h00000000},
		{5'h01, 3'h0, 6'h02, 32'h06040000}, {5'h01, 3'h0, 6'h03, 32'h00010000},
		{5'h09, 3'h0, 6'h03, 32'h00010000}, {5'h10, 3'h4, 6'h02, 32'h06000000},
		{5'h10, 3'h0, 6'h03, 32'h00800000}, {5'h11, 3'h0, 6'h03, 32'h00000000},
		{5'h15, 3'h1, 6'h03, 32'h00800000}, {5'h16, 3'h0, 6'h03, 32'h00800000},
		{5'h00, 3'h0, 6'h0b, 32'h00011d0f}, {5'h01, 3'h0, 6'h0b, 32'h00000000},
		{5'h10, 3'h3, 6'h0b, 32'h00000000}, {5'h12, 3'h0, 6'h02, 32'h00000000},
		{5'h00, 3'h0, 6'h00, 32'h00000000}};

	always #4 clock = ~clock;

	phir_header_ident_regs DUT (
		.clock(clock), .reset(reset), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
		.cfgDevice(cfgDevice), .cfgFunction(cfgFunction), .cfgDword(cfgDword),
		.cfgByteEnable(cfgByteEnable), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
		.cfgReadValid(cfgReadValid), .cfgClaim(cfgClaim), .makerLocked(makerLocked),
		.identLocked(identLocked));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk

	// Requests drop one edge after rising, so back-to-back calls leave an idle cycle.
	task req(input logic wr, input logic [4:0] dev, input logic [2:0] fn,
			input logic [5:0] dw, input logic [3:0] be, input logic [31:0] data);
		@(posedge clock);
		cfgRead <= !wr;
		cfgWrite <= wr;
		cfgDevice <= dev;
		cfgFunction <= fn;
		cfgDword <= dw;
		cfgByteEnable <= be;
		cfgWriteData <= data;
		@(posedge clock);
		cfgRead <= 1'b0;
		cfgWrite <= 1'b0;
		#1;
	endtask : req

	task rd(input logic [4:0] dev, input logic [2:0] fn, input logic [5:0] dw,
			input logic [31:0] exp);
		req(1'b0, dev, fn, dw, 4'h0, 32'h0);
		chk({31'h0, cfgReadValid}, 32'h1);
		chk(cfgReadData, exp);
	endtask : rd

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (1000) @(posedge clock);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		foreach (rows[i]) rd(rows[i][45:41], rows[i][40:38], rows[i][37:32], rows[i][31:0]);
		// The address stays on the bus after a read, so the claim can be checked here.
		rd(5'h10, 3'h5, 6'h02, 32'h00000000);
		chk({31'h0, cfgClaim}, 32'h0);
		rd(5'h10, 3'h4, 6'h03, 32'h00800000);
		chk({31'h0, cfgClaim}, 32'h1);
		req(1'b1, 5'h00, 3'h0, 6'h02, 4'hf, 32'hffffffff);
		rd(5'h00, 3'h0, 6'h02, 32'h06000000);
		req(1'b1, 5'h10, 3'h0, 6'h03, 4'hf, 32'hffffffff);
		rd(5'h10, 3'h0, 6'h03, 32'h00800000);
		req(1'b1, 5'h10, 3'h1, 6'h0b, 4'h1, 32'h000000ab);
		rd(5'h15, 3'h1, 6'h0b, 32'h00011dab);
		req(1'b1, 5'h00, 3'h0, 6'h0b, 4'h3, 32'h000034cd);
		rd(5'h00, 3'h0, 6'h0b, 32'h000134ab);
		req(1'b1, 5'h03, 3'h0, 6'h0b, 4'hc, 32'h55660000);
		rd(5'h16, 3'h1, 6'h0b, 32'h000134ab);
		req(1'b1, 5'h00, 3'h0, 6'h0b, 4'hc, 32'h55660000);
		req(1'b1, 5'h11, 3'h0, 6'h0b, 4'hc, 32'h77880000);
		rd(5'h00, 3'h0, 6'h0b, 32'h556634ab);
		chk({28'h0, makerLocked, identLocked}, 32'hf);
		@(posedge clock);
		reset <= 1'b1;
		@(posedge clock);
		reset <= 1'b0;
		rd(5'h00, 3'h0, 6'h0b, 32'h00011d0f);
		chk({28'h0, makerLocked, identLocked}, 32'h0);
		tally_and_finish();
	end
endmodule : phir_header_ident_regs_tb

// ===== phir_once_byte.sv
`timescale 1ns/10ps
module phir_once_byte #(
	parameter logic [7:0] RESET_VALUE = 8'h00 // Contents after reset.
) (
	input  wire logic       clock,     // Core clock.
	input  wire logic       reset,     // Synchronous reset, active high.
	input  wire logic       write,     // Write strobe for this byte.
	input  wire logic [7:0] writeData, // Byte to store.
	output logic [7:0]      value,     // Stored byte.
	output logic            locked     // Byte has taken its one write.
);
	logic [7:0] next_value;
	logic       next_locked;

	always_comb begin
		next_value  = value;
		next_locked = locked;
		if (write && !locked) begin
			next_value  = writeData;
			next_locked = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			value  <= RESET_VALUE;
			locked <= 1'b0;
		end else begin
			value  <= next_value;
			locked <= next_locked;
		end
	end
endmodule : phir_once_byte

// ===== phir_pkg.sv
package phir_pkg;

	// Configuration offsets in bytes, as seen by software.
	localparam logic [7:0] CLASS_CODE_OFS      = 8'h09;
	localparam logic [7:0] HEADER_LAYOUT_OFS   = 8'h0e;
	localparam logic [7:0] SUBSYS_MAKER_OFS    = 8'h2c;
	localparam logic [7:0] SUBSYS_IDENT_OFS    = 8'h2e;

	// Dword index and first byte lane of each register.
	localparam logic [5:0] CLASS_CODE_DW       = CLASS_CODE_OFS[7:2];
	localparam logic [1:0] CLASS_CODE_LANE     = CLASS_CODE_OFS[1:0];
	localparam logic [5:0] HEADER_LAYOUT_DW    = HEADER_LAYOUT_OFS[7:2];
	localparam logic [1:0] HEADER_LAYOUT_LANE  = HEADER_LAYOUT_OFS[1:0];
	localparam logic [5:0] SUBSYS_DW           = SUBSYS_MAKER_OFS[7:2];
	localparam logic [1:0] SUBSYS_MAKER_LANE   = SUBSYS_MAKER_OFS[1:0];
	localparam logic [1:0] SUBSYS_IDENT_LANE   = SUBSYS_IDENT_OFS[1:0];

	// Class code fields.
	localparam int         BASE_CLASS_LSB      = 16;
	localparam int         SUB_CLASS_LSB       = 8;
	localparam int         PROG_IF_LSB         = 0;
	localparam logic [7:0] BASE_CLASS_BRIDGE   = 8'h06;
	localparam logic [7:0] SUB_CLASS_P2P       = 8'h04;
	localparam logic [7:0] SUB_CLASS_HOST      = 8'h00;
	localparam logic [7:0] PROG_IF_NONE        = 8'h00;

	// Header-type byte fields.
	localparam int         MULTI_FUNC_BIT      = 7;
	localparam logic [6:0] LAYOUT_BRIDGE       = 7'h01;
	localparam logic [6:0] LAYOUT_NORMAL       = 7'h00;

	// Device numbers that shape the identity values.
	localparam logic [4:0] DEV_HOST            = 5'h00;
	localparam logic [4:0] DEV_PORT_FIRST      = 5'h01;
	localparam logic [4:0] DEV_PORT_LAST       = 5'h09;
	localparam logic [4:0] DEV_MULTI_A         = 5'h10;
	localparam logic [4:0] DEV_SINGLE          = 5'h11;
	localparam logic [4:0] DEV_MULTI_B         = 5'h15;
	localparam logic [4:0] DEV_MULTI_C         = 5'h16;
	localparam logic [2:0] FN_MULTI_A_LAST     = 3'h4;
	localparam logic [2:0] FN_SUBSYS_A_LAST    = 3'h2;
	localparam logic [2:0] FN_MULTI_BC_LAST    = 3'h1;

	// Arbitrary neutral subsystem defaults.
	localparam logic [15:0] SUBSYS_MAKER_RESET = 16'h1d0f;
	localparam logic [15:0] SUBSYS_IDENT_RESET = 16'h0001;

endpackage : phir_pkg
